// ---- core/ams_mute_select.sv ----
// mute input source select for the three audio serial ports
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module ams_mute_select #(
  parameter int unsigned NUM_PORTS = ams_pkg::AMS_NUM_PORTS,
  parameter int unsigned DATA_W    = ams_pkg::AMS_DATA_W
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  input  wire ams_pkg::ams_bus_req_t i_bus,
  output var  logic [DATA_W-1:0]    o_rdata,
  input  wire ams_pkg::ams_src_t    i_src,
  output var  logic [NUM_PORTS-1:0] o_mute_in,
  input  wire logic [NUM_PORTS-1:0] i_rx_bus_sel,
  input  wire logic [NUM_PORTS-1:0] i_rx_buf_rd,
  input  wire logic [DATA_W-1:0]    i_rx_buf_data [NUM_PORTS],
  output var  logic [NUM_PORTS-1:0] o_rx_buf_valid,
  output var  logic [DATA_W-1:0]    o_rx_buf_rdata [NUM_PORTS]
);

  // ==========================================================================
  // local sizes
  // ==========================================================================
  localparam int unsigned SEL_W = ams_pkg::AMS_SEL_W;
  localparam int unsigned PAD_W = DATA_W - SEL_W;

  typedef logic [SEL_W-1:0] ams_sel_t;

  // ==========================================================================
  // eight-way source mux
  // ==========================================================================
  // code 000 is a constant, so a cleared field can never mute a port
  function automatic logic mux_src(
    input ams_sel_t          sel,
    input ams_pkg::ams_src_t s
  );
    logic v;
    v = 1'b0;
    unique case (sel)
      ams_pkg::AMS_SEL_ZERO:          v = 1'b0;
      ams_pkg::AMS_SEL_SDATA7:        v = s.sdata7_second_spi_clock_pin;
      ams_pkg::AMS_SEL_SDATA8:        v = s.sdata8_second_spi_slave_out_pin;
      ams_pkg::AMS_SEL_SDATA9:        v = s.sdata9_second_spi_slave_in_pin;
      ams_pkg::AMS_SEL_P2_RX_HFCK:    v = s.port2_rx_high_freq_clock;
      ams_pkg::AMS_SEL_SPI0_SLAVE_IN: v = s.first_spi_slave_in_pin;
      ams_pkg::AMS_SEL_SPI0_CS:       v = s.first_spi_chip_select_pin;
      ams_pkg::AMS_SEL_SPI0_ENABLE:   v = s.first_spi_enable_pin;
    endcase
    return v;
  endfunction : mux_src

  // ==========================================================================
  // address decode
  // ==========================================================================
  wire logic [NUM_PORTS-1:0] cfg_hit;
  wire logic [NUM_PORTS-1:0] cfg_wr;
  wire logic [NUM_PORTS-1:0] cfg_rd;

  genvar gd;
  generate
    for (gd = 0; gd < NUM_PORTS; gd++)
    begin : g_decode
      // full byte address compare, so nothing aliases across the map
      assign cfg_hit[gd] = (i_bus.addr == ams_pkg::ams_cfg_addr(gd));
      assign cfg_wr[gd]  = i_bus.wr && cfg_hit[gd];
      assign cfg_rd[gd]  = i_bus.rd && cfg_hit[gd];
    end
  endgenerate

  // ==========================================================================
  // select fields
  // ==========================================================================
  ams_sel_t sel_r [NUM_PORTS];

  genvar gs;
  generate
    for (gs = 0; gs < NUM_PORTS; gs++)
    begin : g_sel
      ams_sel_t sel_nxt;

      always_comb
      begin
        sel_nxt = sel_r[gs];
        // upper bits are dropped; software keeps them zero
        if (cfg_wr[gs])
        begin
          sel_nxt = i_bus.wdata[ams_pkg::AMS_SEL_LSB +: SEL_W];
        end
      end

      always_ff @(posedge i_clk or negedge i_resetn)
      begin
        if (!i_resetn)
        begin
          sel_r[gs] <= ams_pkg::AMS_SEL_RESET;
        end
        else
        begin
          sel_r[gs] <= sel_nxt;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // mute outputs
  // ==========================================================================
  genvar gm;
  generate
    for (gm = 0; gm < NUM_PORTS; gm++)
    begin : g_mute
      logic mute_nxt;

      always_comb
      begin
        // mux reads the stored field: one cycle late, but never glitches
        mute_nxt = mux_src(sel_r[gm], i_src);
      end

      always_ff @(posedge i_clk or negedge i_resetn)
      begin
        if (!i_resetn)
        begin
          o_mute_in[gm] <= ams_pkg::AMS_MUTE_RESET;
        end
        else
        begin
          o_mute_in[gm] <= mute_nxt;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // receive buffer read gate
  // ==========================================================================
  genvar gr;
  generate
    for (gr = 0; gr < NUM_PORTS; gr++)
    begin : g_rx
      logic              rxv_nxt;
      logic [DATA_W-1:0] rxd_nxt;

      always_comb
      begin
        // idle data is zero so a refused read leaks nothing
        rxv_nxt = i_rx_buf_rd[gr] && i_rx_bus_sel[gr];
        rxd_nxt = rxv_nxt ? i_rx_buf_data[gr] : DATA_W'(ams_pkg::AMS_RDATA_IDLE);
      end

      always_ff @(posedge i_clk or negedge i_resetn)
      begin
        if (!i_resetn)
        begin
          o_rx_buf_valid[gr] <= ams_pkg::AMS_RXV_RESET;
          o_rx_buf_rdata[gr] <= DATA_W'(ams_pkg::AMS_RDATA_IDLE);
        end
        else
        begin
          o_rx_buf_valid[gr] <= rxv_nxt;
          o_rx_buf_rdata[gr] <= rxd_nxt;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // register images
  // ==========================================================================
  wire logic [DATA_W-1:0] cfg_image [NUM_PORTS];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++)
    begin : g_image
      // reserved bits read as zero rather than whatever was written
      assign cfg_image[gi] = {{PAD_W{1'b0}}, sel_r[gi]};
    end
  endgenerate

  // ==========================================================================
  // register read port
  // ==========================================================================
  logic [DATA_W-1:0] rdata_nxt;

  always_comb
  begin
    // unmapped addresses read as zero; data stands for one cycle only
    rdata_nxt = DATA_W'(ams_pkg::AMS_RDATA_IDLE);
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (cfg_rd[p])
      begin
        rdata_nxt = cfg_image[p];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_rdata <= DATA_W'(ams_pkg::AMS_RDATA_IDLE);
    end
    else
    begin
      o_rdata <= rdata_nxt;
    end
  end

endmodule : ams_mute_select

`default_nettype wire

// ---- core/ams_pkg.sv ----
// package for the audio mute source select block
package ams_pkg;

  // ==========================================================================
  // sizes
  // ==========================================================================
  localparam int unsigned AMS_NUM_PORTS  = 3;
  localparam int unsigned AMS_ADDR_W     = 32;
  localparam int unsigned AMS_DATA_W     = 32;
  localparam int unsigned AMS_SEL_W      = 3;

  // ==========================================================================
  // register byte addresses
  // ==========================================================================
  localparam logic [31:0] AMS_PORT0_MUTE_CFG_REG = 32'h4000_0018;
  localparam logic [31:0] AMS_PORT1_MUTE_CFG_REG = 32'h4000_001C;
  localparam logic [31:0] AMS_PORT2_MUTE_CFG_REG = 32'h4000_0020;

  // ==========================================================================
  // field layout and reset values
  // ==========================================================================
  localparam int unsigned AMS_SEL_LSB    = 0;
  localparam logic [2:0]  AMS_SEL_RESET  = 3'h0;
  localparam logic [31:0] AMS_RDATA_IDLE = 32'h0000_0000;
  localparam logic        AMS_MUTE_RESET = 1'h0;
  localparam logic        AMS_RXV_RESET  = 1'h0;

  // ==========================================================================
  // mute source select codes
  // ==========================================================================
  localparam logic [2:0] AMS_SEL_ZERO       = 3'h0;
  localparam logic [2:0] AMS_SEL_SDATA7     = 3'h1;
  localparam logic [2:0] AMS_SEL_SDATA8     = 3'h2;
  localparam logic [2:0] AMS_SEL_SDATA9     = 3'h3;
  localparam logic [2:0] AMS_SEL_P2_RX_HFCK = 3'h4;
  localparam logic [2:0] AMS_SEL_SPI0_SLAVE_IN = 3'h5;
  localparam logic [2:0] AMS_SEL_SPI0_CS       = 3'h6;
  localparam logic [2:0] AMS_SEL_SPI0_ENABLE   = 3'h7;

  // ==========================================================================
  // carriers
  // ==========================================================================
  typedef struct packed {
    logic sdata7_second_spi_clock_pin;
    logic sdata8_second_spi_slave_out_pin;
    logic sdata9_second_spi_slave_in_pin;
    logic port2_rx_high_freq_clock;
    logic first_spi_slave_in_pin;
    logic first_spi_chip_select_pin;
    logic first_spi_enable_pin;
  } ams_src_t;

  typedef struct packed {
    logic [AMS_ADDR_W-1:0] addr;
    logic [AMS_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } ams_bus_req_t;

  function automatic logic [31:0] ams_cfg_addr(input int unsigned port);
    logic [31:0] a;
    a = AMS_PORT0_MUTE_CFG_REG;
    if (port == 1)
      a = AMS_PORT1_MUTE_CFG_REG;
    else if (port == 2)
      a = AMS_PORT2_MUTE_CFG_REG;
    return a;
  endfunction : ams_cfg_addr

endpackage : ams_pkg

// ---- testbench/ams_assertions.sv ----
// checker for the mute source select block
`timescale 1ns/1ns
`default_nettype none
module ams_assertions (
  input wire logic                  i_clk,
  input wire logic                  i_resetn,
  input wire ams_pkg::ams_bus_req_t i_bus,
  input wire logic [31:0]           o_rdata,
  input wire ams_pkg::ams_src_t     i_src,
  input wire logic [2:0]            o_mute_in,
  input wire logic [2:0]            i_rx_bus_sel,
  input wire logic [2:0]            i_rx_buf_rd,
  input wire logic [31:0]           i_rx_buf_data [3],
  input wire logic [2:0]            o_rx_buf_valid,
  input wire logic [31:0]           o_rx_buf_rdata [3]
);
  logic [2:0] sel_r [3];
  // shadow of the three select fields
  always_ff @(posedge i_clk or negedge i_resetn)
    if (!i_resetn)
      sel_r <= '{3'h0, 3'h0, 3'h0};
    else if (i_bus.wr)
      for (int p = 0; p < 3; p++)
        if (i_bus.addr == 32'h4000_0018 + 32'(4 * p))
          sel_r[p] <= i_bus.wdata[2:0];
  function automatic logic pick(input logic [2:0] c, input ams_pkg::ams_src_t s);
    return (c == 3'h0) ? 1'b0 : s[3'h7 - c];
  endfunction : pick
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  AST_MUTE0: assert property (o_mute_in[0] == pick($past(sel_r[0]), $past(i_src))) else $error("mute 0");
  AST_MUTE1: assert property (o_mute_in[1] == pick($past(sel_r[1]), $past(i_src))) else $error("mute 1");
  AST_MUTE2: assert property (o_mute_in[2] == pick($past(sel_r[2]), $past(i_src))) else $error("mute 2");
  AST_RD1: assert property ($past(i_bus.rd) && $past(i_bus.addr) == 32'h4000_001C
    |-> o_rdata == {29'h0, $past(sel_r[1])}) else $error("read 1");
  AST_RSVD: assert property (o_rdata[31:3] == 29'h0) else $error("reserved");
  AST_RXV: assert property (o_rx_buf_valid == $past(i_rx_buf_rd & i_rx_bus_sel)) else $error("rx v");
  AST_RXD: assert property (o_rx_buf_valid[1] |-> o_rx_buf_rdata[1] == $past(i_rx_buf_data[1]))
    else $error("rx d");
  AST_RXZ: assert property (!o_rx_buf_valid[2] |-> o_rx_buf_rdata[2] == 32'h0) else $error("rx z");
endmodule : ams_assertions
bind ams_mute_select ams_assertions u_chk (.*);
`default_nettype wire

// ---- testbench/ams_rx_model.sv ----
// far side: receive buffer contents of the three ports
`timescale 1ns/1ns
`default_nettype none
module ams_rx_model (
  input wire logic  i_clk,
  output var logic [31:0] o_data [3]
);
  logic [31:0] cnt_r = 32'h0;
  // contents move every cycle so a stale capture shows
  always @(posedge i_clk) cnt_r <= cnt_r + 32'h9E37_79B9;
  always_comb foreach (o_data[i]) o_data[i] = cnt_r ^ (32'h1 << i);
endmodule : ams_rx_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench for the mute source select block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic i_clk = 1'b0, i_resetn = 1'b0;
  ams_pkg::ams_bus_req_t bus = '0;
  ams_pkg::ams_src_t src = '0;
  logic [2:0] mute, rxv, sel = 3'h0, rxrd = 3'h0;
  logic [31:0] rdata, d, rxd [3], rxq [3];
  logic em;
  int errors = 0, n_tests = 0, seed = 32'h8E717B0A;
  always #2 i_clk = ~i_clk;
  ams_mute_select dut (.i_clk, .i_resetn, .i_bus(bus), .o_rdata(rdata), .i_src(src), .o_mute_in(mute),
    .i_rx_bus_sel(sel), .i_rx_buf_rd(rxrd), .i_rx_buf_data(rxd), .o_rx_buf_valid(rxv), .o_rx_buf_rdata(rxq));
  ams_rx_model u_rx (.i_clk, .o_data(rxd));
  function automatic logic pick(input logic [2:0] c, input ams_pkg::ams_src_t s);
    return (c == 3'h0) ? 1'b0 : s[3'h7 - c];
  endfunction : pick
  task cmp(input logic [31:0] s, e, input string n);
    n_tests++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task chk_rdata(input logic [31:0] s, e);
    cmp(s, e, "rdata");
  endtask : chk_rdata
  task chk_mute(input logic s, e);
    cmp({31'h0, s}, {31'h0, e}, "mute");
  endtask : chk_mute
  task chk_rx(input logic [31:0] s, e, input string n);
    cmp(s, e, n);
  endtask : chk_rx
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task wr(input logic [31:0] a, w);
    @(posedge i_clk);
    bus <= '{a, w, 1'b1, 1'b0};
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task rd(input logic [31:0] a, e);
    @(posedge i_clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1 chk_rdata(rdata, e);
  endtask : rd
  initial
  begin
    #20000 errors++;
    tally_and_finish;
  end
  initial
  begin
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    for (int p = 0; p < 3; p++)
      rd(32'h4000_0018 + 4 * p, 32'h0);
    $display("test reset done");
    for (int p = 0; p < 3; p++)
      for (int c = 0; c < 8; c++)
      begin
        wr(32'h4000_0018 + 4 * p, c);
        src <= 7'($random(seed));
        repeat (2)
        begin
          @(posedge i_clk);
          em = pick(c, src);
          src <= ~src;
          #1 chk_mute(mute[p], em);
        end
        rd(32'h4000_0018 + 4 * p, c);
      end
    $display("test codes done");
    wr(32'h4000_0024, 32'h5);
    rd(32'h4000_0024, 32'h0);
    rd(32'h4000_0020, 32'h7);
    $display("test unmapped done");
    for (int k = 0; k < 15; k++)
    begin
      @(posedge i_clk);
      rxrd <= 3'h1 << (k % 3);
      sel <= (k < 3) ? 3'h7 : 3'($random(seed));
      #1 d = rxd[k % 3];
      @(posedge i_clk);
      rxrd <= 3'h0;
      #1 chk_rx({31'h0, rxv[k % 3]}, {31'h0, sel[k % 3]}, "rx valid");
      chk_rx(rxq[k % 3], sel[k % 3] ? d : 32'h0, "rx data");
    end
    $display("test rx gate done");
    tally_and_finish;
  end
endmodule : testbench
`default_nettype wire
